// File: src/fdp_pkg.sv
/*
 * package for the front side bus data phase control ends: widths, lane map, timing counts.
 * assumes both ends share one clock, clk_sys at 100 MHz.
 */
package fdp_pkg;
    // ---------------------------------------------------------------
    // widths
    // ---------------------------------------------------------------
    localparam int DATA_W   = 64;
    localparam int LANE_W   = 16;
    localparam int LANES    = 4;
    // ---------------------------------------------------------------
    // lane positions and inversion limit
    // ---------------------------------------------------------------
    localparam int LANE0_LSB = 0;
    localparam int LANE1_LSB = 16;
    localparam int LANE2_LSB = 32;
    localparam int LANE3_LSB = 48;
    localparam int INV_LIMIT = 8;
    // ---------------------------------------------------------------
    // reset values and counts
    // ---------------------------------------------------------------
    localparam logic [63:0] DATA_RST   = 64'h0;
    localparam logic [3:0]  FLAGS_RST  = 4'h0;
    localparam int          TURN_CYC   = 1;
    localparam logic [4:0]  INV_LIMIT5 = 5'h08;

    typedef enum logic [1:0] {FDP_IDLE, FDP_DRIVE, FDP_RELEASE} fdp_state_t;
endpackage

// File: src/fdp_bus_if.sv
/*
 * shared data phase wires of the front side bus between the processor end and the agent end.
 * assumes the testbench resolves the wired lines from the two enables.
 */
`timescale 1ns/100ps
interface fdp_bus_if;
    // ---------------------------------------------------------------
    // processor end drive
    // ---------------------------------------------------------------
    logic [63:0] cpu_data;
    logic [3:0]  cpu_parity;
    logic [3:0]  cpu_invert;
    logic        cpu_valid;
    logic        cpu_in_use;
    logic        cpu_oe;
    // ---------------------------------------------------------------
    // agent end drive
    // ---------------------------------------------------------------
    logic [63:0] agt_data;
    logic [3:0]  agt_parity;
    logic [3:0]  agt_invert;
    logic        agt_valid;
    logic        agt_in_use;
    logic        agt_oe;
    logic        out_of_order_indication;
    logic        debug_system_reset;

    modport cpu_end (
        output cpu_data, cpu_parity, cpu_invert, cpu_valid, cpu_in_use, cpu_oe,
        input  agt_data, agt_parity, agt_invert, agt_valid, agt_in_use, agt_oe,
        input  out_of_order_indication, debug_system_reset
    );
    modport agent_end (
        output agt_data, agt_parity, agt_invert, agt_valid, agt_in_use, agt_oe,
        output out_of_order_indication, debug_system_reset,
        input  cpu_data, cpu_parity, cpu_invert, cpu_valid, cpu_in_use, cpu_oe
    );
endinterface // fdp_bus_if

// File: src/fdp_agent.sv
/*
 * agent end (chipset side) of the data phase control: drives data phases, out_of_order_indication and debug reset.
 * assumes the processor end keeps off the data path while this end's in-use flag is high.
 */
`timescale 1ns/100ps
module fdp_agent (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // bus side
    fdp_bus_if.agent_end     bus,
    // user: outgoing transfer
    input  wire logic        tx_req,
    input  wire logic [63:0] tx_data,
    input  wire logic        tx_last,
    input  wire logic        tx_idle,
    input  wire logic        out_of_order_indication_req,
    input  wire logic        probe_reset_req,
    output logic             tx_taken,
    // user: incoming transfer
    output logic [63:0]      rx_data,
    output logic             rx_valid,
    output logic             rx_parity_err
);
    // ---------------------------------------------------------------
    // lane encode and decode
    // ---------------------------------------------------------------
    logic [63:0] enc_data;
    logic [3:0]  enc_inv;
    logic [3:0]  enc_par;
    logic [63:0] dec_data;
    logic [3:0]  dec_par;
    logic [63:0] cin_data;
    logic [3:0]  cin_par;
    logic [3:0]  cin_inv;
    logic        cin_valid;
    logic        cin_use;
    logic        cin_use_q;

    genvar g;
    generate
        for (g = 0; g < fdp_pkg::LANES; g++) begin : g_lane
            logic [15:0] raw;
            logic [4:0]  ones;
            assign raw = tx_data[g*fdp_pkg::LANE_W +: fdp_pkg::LANE_W];
            assign ones = 5'($countones(raw));
            // too few ones means most bits low: invert lane
            assign enc_inv[g] = (5'(16) - ones) > fdp_pkg::INV_LIMIT5;
            assign enc_data[g*16 +: 16] = enc_inv[g] ? ~raw : raw;
            assign enc_par[g] = ^{enc_data[g*16 +: 16], enc_inv[g]};
            assign dec_data[g*16 +: 16] = cin_inv[g] ? ~cin_data[g*16 +: 16] : cin_data[g*16 +: 16];
            assign dec_par[g] = ^{cin_data[g*16 +: 16], cin_inv[g]};
        end
    endgenerate

    // ---------------------------------------------------------------
    // input capture
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cin_data  <= fdp_pkg::DATA_RST;
            cin_par   <= fdp_pkg::FLAGS_RST;
            cin_inv   <= fdp_pkg::FLAGS_RST;
            cin_valid <= 1'b0;
            cin_use   <= 1'b0;
            cin_use_q <= 1'b0;
        end else begin
            cin_data  <= bus.cpu_data;
            cin_par   <= bus.cpu_parity;
            cin_inv   <= bus.cpu_invert;
            cin_valid <= bus.cpu_valid;
            cin_use   <= bus.cpu_in_use;
            cin_use_q <= cin_use;
        end
    end

    // ---------------------------------------------------------------
    // drive state
    // ---------------------------------------------------------------
    fdp_pkg::fdp_state_t st_q, st_d;
    logic [63:0] dat_q, dat_d;
    logic [3:0]  par_q, par_d, inv_q, inv_d;
    logic        val_q, val_d, use_q, use_d, oe_q, oe_d, tk_q, tk_d;
    logic        dfr_q, dfr_d, dbr_q, dbr_d;
    logic [63:0] rxd_q, rxd_d;
    logic        rxv_q, rxv_d, rxe_q, rxe_d;

    always_comb begin
        st_d  = st_q;
        dat_d = dat_q;
        par_d = par_q;
        inv_d = inv_q;
        val_d = 1'b0;
        use_d = use_q;
        oe_d  = oe_q;
        tk_d  = 1'b0;
        dfr_d = out_of_order_indication_req;
        dbr_d = probe_reset_req;
        rxv_d = cin_valid;
        rxd_d = cin_valid ? dec_data : rxd_q;
        rxe_d = cin_valid && (dec_par != cin_par);
        unique case (st_q)
            fdp_pkg::FDP_IDLE: begin
                // wait until the other end has let go
                if (tx_req && !bus.cpu_in_use && !cin_use && !cin_use_q) begin
                    st_d  = fdp_pkg::FDP_DRIVE;
                    use_d = 1'b1;
                    oe_d  = 1'b1;
                end
            end
            fdp_pkg::FDP_DRIVE: begin
                if (tx_req && !tx_idle) begin
                    dat_d = enc_data;
                    inv_d = enc_inv;
                    par_d = enc_par;
                    val_d = 1'b1;
                    tk_d  = 1'b1;
                    if (tx_last) begin
                        st_d = fdp_pkg::FDP_RELEASE;
                    end
                end
            end
            fdp_pkg::FDP_RELEASE: begin
                use_d = 1'b0;
                oe_d  = 1'b0;
                st_d  = fdp_pkg::FDP_IDLE;
            end
            default: st_d = fdp_pkg::FDP_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_q  <= fdp_pkg::FDP_IDLE;
            dat_q <= fdp_pkg::DATA_RST;
            par_q <= fdp_pkg::FLAGS_RST;
            inv_q <= fdp_pkg::FLAGS_RST;
            val_q <= 1'b0;
            use_q <= 1'b0;
            oe_q  <= 1'b0;
            tk_q  <= 1'b0;
            dfr_q <= 1'b0;
            dbr_q <= 1'b0;
            rxd_q <= fdp_pkg::DATA_RST;
            rxv_q <= 1'b0;
            rxe_q <= 1'b0;
        end else begin
            st_q  <= st_d;
            dat_q <= dat_d;
            par_q <= par_d;
            inv_q <= inv_d;
            val_q <= val_d;
            use_q <= use_d;
            oe_q  <= oe_d;
            tk_q  <= tk_d;
            dfr_q <= dfr_d;
            dbr_q <= dbr_d;
            rxd_q <= rxd_d;
            rxv_q <= rxv_d;
            rxe_q <= rxe_d;
        end
    end

    assign bus.agt_data   = dat_q;
    assign bus.agt_parity = par_q;
    assign bus.agt_invert = inv_q;
    assign bus.agt_valid  = val_q;
    assign bus.agt_in_use = use_q;
    assign bus.agt_oe     = oe_q;
    assign bus.out_of_order_indication = dfr_q;
    assign bus.debug_system_reset      = dbr_q;
    assign tx_taken      = tk_q;
    assign rx_data       = rxd_q;
    assign rx_valid      = rxv_q;
    assign rx_parity_err = rxe_q;
endmodule // fdp_agent

// File: src/fdp_cpu.sv
/*
 * processor end of the data phase control: drives and receives data phases, sees out_of_order_indication.
 * assumes the agent end keeps off the data path while this end's in-use flag is high.
 */
`timescale 1ns/100ps
// Notes on behaviour
// - driver holds in-use while it owns data
// - take data path only after in-use drops
// - addressed agent raises out-of-order indication
// - four parity lines guard sixty-four data
// - parity driven only by current data driver
// - invert lane when over half bits low
// - data-valid per transfer, gaps allowed
module fdp_cpu (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // bus side
    fdp_bus_if.cpu_end       bus,
    // user: outgoing transfer
    input  wire logic        tx_req,
    input  wire logic [63:0] tx_data,
    input  wire logic        tx_last,
    input  wire logic        tx_idle,
    output logic             tx_taken,
    // user: incoming transfer and status
    output logic [63:0]      rx_data,
    output logic             rx_valid,
    output logic             rx_parity_err,
    output logic             deferred,
    output logic             probe_reset_seen
);
    // ---------------------------------------------------------------
    // lane encode and decode
    // ---------------------------------------------------------------
    logic [63:0] enc_data;
    logic [3:0]  enc_inv;
    logic [3:0]  enc_par;
    logic [63:0] dec_data;
    logic [3:0]  dec_par;
    logic [63:0] cin_data;
    logic [3:0]  cin_par;
    logic [3:0]  cin_inv;
    logic        cin_valid;
    logic        cin_use;
    logic        cin_use_q;
    logic        cin_dfr;
    logic        cin_dbr;

    genvar g;
    generate
        for (g = 0; g < fdp_pkg::LANES; g++) begin : g_lane
            logic [15:0] raw;
            logic [4:0]  ones;
            assign raw = tx_data[g*fdp_pkg::LANE_W +: fdp_pkg::LANE_W];
            assign ones = 5'($countones(raw));
            // invert lane when more than half its bits are low
            assign enc_inv[g] = (5'(16) - ones) > fdp_pkg::INV_LIMIT5;
            assign enc_data[g*16 +: 16] = enc_inv[g] ? ~raw : raw;
            assign enc_par[g] = ^{enc_data[g*16 +: 16], enc_inv[g]};
            assign dec_data[g*16 +: 16] = cin_inv[g] ? ~cin_data[g*16 +: 16] : cin_data[g*16 +: 16];
            assign dec_par[g] = ^{cin_data[g*16 +: 16], cin_inv[g]};
        end
    endgenerate

    // ---------------------------------------------------------------
    // input capture
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cin_data  <= fdp_pkg::DATA_RST;
            cin_par   <= fdp_pkg::FLAGS_RST;
            cin_inv   <= fdp_pkg::FLAGS_RST;
            cin_valid <= 1'b0;
            cin_use   <= 1'b0;
            cin_use_q <= 1'b0;
            cin_dfr   <= 1'b0;
            cin_dbr   <= 1'b0;
        end else begin
            cin_data  <= bus.agt_data;
            cin_par   <= bus.agt_parity;
            cin_inv   <= bus.agt_invert;
            cin_valid <= bus.agt_valid;
            cin_use   <= bus.agt_in_use;
            cin_use_q <= cin_use;
            cin_dfr   <= bus.out_of_order_indication;
            cin_dbr   <= bus.debug_system_reset;
        end
    end

    // ---------------------------------------------------------------
    // drive state
    // ---------------------------------------------------------------
    fdp_pkg::fdp_state_t st_q, st_d;
    logic [63:0] dat_q, dat_d;
    logic [3:0]  par_q, par_d, inv_q, inv_d;
    logic        val_q, val_d, use_q, use_d, oe_q, oe_d, tk_q, tk_d;
    logic [63:0] rxd_q, rxd_d;
    logic        rxv_q, rxv_d, rxe_q, rxe_d, dfr_q, dbr_q;

    always_comb begin
        st_d  = st_q;
        dat_d = dat_q;
        par_d = par_q;
        inv_d = inv_q;
        val_d = 1'b0;
        use_d = use_q;
        oe_d  = oe_q;
        tk_d  = 1'b0;
        rxv_d = cin_valid;
        rxd_d = cin_valid ? dec_data : rxd_q;
        rxe_d = cin_valid && (dec_par != cin_par);
        unique case (st_q)
            fdp_pkg::FDP_IDLE: begin
                // no takeover before other end drops in-use
                if (tx_req && !bus.agt_in_use && !cin_use && !cin_use_q) begin
                    st_d  = fdp_pkg::FDP_DRIVE;
                    use_d = 1'b1;
                    oe_d  = 1'b1;
                end
            end
            fdp_pkg::FDP_DRIVE: begin
                if (tx_req && !tx_idle) begin
                    dat_d = enc_data;
                    inv_d = enc_inv;
                    par_d = enc_par;
                    val_d = 1'b1;
                    tk_d  = 1'b1;
                    if (tx_last) begin
                        st_d = fdp_pkg::FDP_RELEASE;
                    end
                end
            end
            fdp_pkg::FDP_RELEASE: begin
                use_d = 1'b0;
                oe_d  = 1'b0;
                st_d  = fdp_pkg::FDP_IDLE;
            end
            default: st_d = fdp_pkg::FDP_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_q  <= fdp_pkg::FDP_IDLE;
            dat_q <= fdp_pkg::DATA_RST;
            par_q <= fdp_pkg::FLAGS_RST;
            inv_q <= fdp_pkg::FLAGS_RST;
            val_q <= 1'b0;
            use_q <= 1'b0;
            oe_q  <= 1'b0;
            tk_q  <= 1'b0;
            rxd_q <= fdp_pkg::DATA_RST;
            rxv_q <= 1'b0;
            rxe_q <= 1'b0;
            dfr_q <= 1'b0;
            dbr_q <= 1'b0;
        end else begin
            st_q  <= st_d;
            dat_q <= dat_d;
            par_q <= par_d;
            inv_q <= inv_d;
            val_q <= val_d;
            use_q <= use_d;
            oe_q  <= oe_d;
            tk_q  <= tk_d;
            rxd_q <= rxd_d;
            rxv_q <= rxv_d;
            rxe_q <= rxe_d;
            dfr_q <= cin_dfr;
            dbr_q <= cin_dbr;
        end
    end

    assign bus.cpu_data   = dat_q;
    assign bus.cpu_parity = par_q;
    assign bus.cpu_invert = inv_q;
    assign bus.cpu_valid  = val_q;
    assign bus.cpu_in_use = use_q;
    assign bus.cpu_oe     = oe_q;
    assign tx_taken         = tk_q;
    assign rx_data          = rxd_q;
    assign rx_valid         = rxv_q;
    assign rx_parity_err    = rxe_q;
    assign deferred         = dfr_q;
    assign probe_reset_seen = dbr_q;
endmodule // fdp_cpu

// File: testbench/fdp_bus_sva.sv
/*
 * checker for the data phase wires between the processor end and the agent end.
 * assumes one clock domain and that the testbench instantiates it beside the interface.
 */
`timescale 1ns/100ps
module fdp_bus_sva (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        reset_n,
    // processor end
    input wire logic [63:0] cpu_data,
    input wire logic [3:0]  cpu_parity,
    input wire logic [3:0]  cpu_invert,
    input wire logic        cpu_valid,
    input wire logic        cpu_in_use,
    input wire logic        cpu_oe,
    // agent end
    input wire logic [63:0] agt_data,
    input wire logic [3:0]  agt_parity,
    input wire logic [3:0]  agt_invert,
    input wire logic        agt_valid,
    input wire logic        agt_in_use,
    input wire logic        agt_oe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    // ---------------------------------------------------------------
    // lane helpers
    // ---------------------------------------------------------------
    function automatic logic [3:0] par_f(logic [63:0] d, logic [3:0] v);
        for (int g = 0; g < 4; g++)
            par_f[g] = (^d[16*g +: 16]) ^ v[g];
    endfunction

    function automatic logic inv_ok_f(logic [63:0] d, logic [3:0] v);
        inv_ok_f = 1'b1;
        for (int g = 0; g < 4; g++)
            if (v[g] ? ($countones(d[16*g +: 16]) <= 8) : ($countones(d[16*g +: 16]) < 8))
                inv_ok_f = 1'b0;
    endfunction

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    cpu_valid_own_a: assert property (cpu_valid |-> cpu_in_use && cpu_oe)
        else $error("cpu beat outside its bus ownership");
    agt_valid_own_a: assert property (agt_valid |-> agt_in_use && agt_oe)
        else $error("agent beat outside its bus ownership");
    oe_follow_a: assert property (cpu_oe == cpu_in_use && agt_oe == agt_in_use)
        else $error("drive enable differs from in use");
    one_driver_a: assert property (!(cpu_oe && agt_oe))
        else $error("both ends drive data and parity");
    cpu_parity_a: assert property (cpu_valid |-> cpu_parity == par_f(cpu_data, cpu_invert))
        else $error("cpu parity wrong");
    agt_parity_a: assert property (agt_valid |-> agt_parity == par_f(agt_data, agt_invert))
        else $error("agent parity wrong");
    cpu_lane_inv_a: assert property (cpu_valid |-> inv_ok_f(cpu_data, cpu_invert))
        else $error("cpu lane inversion wrong");
    agt_lane_inv_a: assert property (agt_valid |-> inv_ok_f(agt_data, agt_invert))
        else $error("agent lane inversion wrong");
    cpu_release_a: assert property ($fell(cpu_in_use) |-> $past(cpu_valid))
        else $error("cpu released without a last beat");
    cpu_claim_a: assert property ($rose(cpu_in_use) |-> !$past(agt_in_use, 1) && !$past(agt_in_use, 2))
        else $error("cpu claimed while agent busy");
    agt_claim_a: assert property ($rose(agt_in_use) |-> !$past(cpu_in_use, 1) && !$past(cpu_in_use, 2))
        else $error("agent claimed while cpu busy");

    // ---------------------------------------------------------------
    // covers
    // ---------------------------------------------------------------
    cpu_gap_c: cover property (cpu_valid ##1 (cpu_in_use && !cpu_valid) ##1 cpu_valid);
    agt_b2b_c: cover property (agt_valid ##1 agt_valid);
    handover_c: cover property ($fell(agt_in_use) ##[1:8] $rose(cpu_in_use));
endmodule // fdp_bus_sva

// File: testbench/testbench.sv
/*
 * self-checking bench joining the processor end and the agent end through one interface.
 * assumes index 0 of the user arrays is the processor end and index 1 the agent end.
 */
`timescale 1ns/100ps
module testbench;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic [1:0]  req     = 2'h0;
    logic [1:0]  last    = 2'h0;
    logic [1:0]  idle    = 2'h0;
    logic [63:0] txd [2] = '{64'h0, 64'h0};
    logic        out_of_order_indication_req = 1'b0;
    logic        probe_req = 1'b0;
    logic [1:0]  taken;
    logic [1:0]  rxv;
    logic [1:0]  rxe;
    logic [63:0] rxd [2];
    logic        deferred;
    logic        probe_seen;
    logic [63:0] pat [3] = '{64'hffff_0000_007f_00ff, 64'h0001_fe00_8000_ffff, 64'h1234_5678_9abc_def0};
    logic [63:0] wire_q [$];
    logic [3:0]  inv_q [$];
    logic [63:0] rx_q [2][$];
    int          n_taken [2] = '{0, 0};
    int          n_errors = 0;
    int          checked = 0;
    int          cyc = 0;

    always #5 clk_sys = ~clk_sys;

    fdp_bus_if bus_if ();
    fdp_cpu i_fdp_cpu (.clk_sys(clk_sys), .reset_n(reset_n), .bus(bus_if), .tx_req(req[0]), .tx_data(txd[0]),
        .tx_last(last[0]), .tx_idle(idle[0]), .tx_taken(taken[0]), .rx_data(rxd[0]), .rx_valid(rxv[0]),
        .rx_parity_err(rxe[0]), .deferred(deferred), .probe_reset_seen(probe_seen));
    fdp_agent i_fdp_agent (.clk_sys(clk_sys), .reset_n(reset_n), .bus(bus_if), .tx_req(req[1]), .tx_data(txd[1]),
        .tx_last(last[1]), .tx_idle(idle[1]), .out_of_order_indication_req(out_of_order_indication_req), .probe_reset_req(probe_req),
        .tx_taken(taken[1]), .rx_data(rxd[1]), .rx_valid(rxv[1]), .rx_parity_err(rxe[1]));
    fdp_bus_sva i_fdp_bus_sva (.clk_sys(clk_sys), .reset_n(reset_n), .cpu_data(bus_if.cpu_data),
        .cpu_parity(bus_if.cpu_parity), .cpu_invert(bus_if.cpu_invert), .cpu_valid(bus_if.cpu_valid),
        .cpu_in_use(bus_if.cpu_in_use), .cpu_oe(bus_if.cpu_oe), .agt_data(bus_if.agt_data),
        .agt_parity(bus_if.agt_parity), .agt_invert(bus_if.agt_invert), .agt_valid(bus_if.agt_valid),
        .agt_in_use(bus_if.agt_in_use), .agt_oe(bus_if.agt_oe));

    // ---------------------------------------------------------------
    // monitors and helpers
    // ---------------------------------------------------------------
    task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(negedge clk_sys) begin
        if (bus_if.cpu_valid === 1'b1) begin
            wire_q.push_back(bus_if.cpu_data);
            inv_q.push_back(bus_if.cpu_invert);
        end
        if (bus_if.agt_valid === 1'b1) begin
            wire_q.push_back(bus_if.agt_data);
            inv_q.push_back(bus_if.agt_invert);
        end
        for (int k = 0; k < 2; k++) begin
            if (taken[k] === 1'b1)
                n_taken[k]++;
            if (rxv[k] === 1'b1) begin
                rx_q[k].push_back(rxd[k]);
                check("rx parity error", 64'(rxe[k]), 64'h0);
            end
        end
    end

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            results();
        end
    end

    function automatic logic [3:0] exp_inv(logic [63:0] d);
        for (int g = 0; g < 4; g++)
            exp_inv[g] = (16 - $countones(d[16*g +: 16])) > fdp_pkg::INV_LIMIT;
    endfunction

    task automatic clear();
        wire_q.delete();
        inv_q.delete();
        rx_q[0].delete();
        rx_q[1].delete();
        n_taken = '{0, 0};
    endtask

    // one end sends n beats of pat, optionally with one idle clock after the first
    task automatic send(int c, int n, bit gap);
        @(posedge clk_sys);
        req[c] <= 1'b1;
        txd[c] <= pat[0];
        last[c] <= (n == 1);
        for (int k = 0; k < 20 && (c ? bus_if.agt_in_use : bus_if.cpu_in_use) !== 1'b1; k++)
            @(negedge clk_sys);
        for (int i = 1; i < n; i++) begin
            @(posedge clk_sys);
            if (gap && i == 1) begin
                idle[c] <= 1'b1;
                @(posedge clk_sys);
                idle[c] <= 1'b0;
            end
            txd[c] <= pat[i];
            last[c] <= (i == n - 1);
        end
        @(posedge clk_sys);
        req[c] <= 1'b0;
        last[c] <= 1'b0;
    endtask

    task automatic expect_beats(int c, int n);
        logic [3:0] e;
        repeat (6) @(posedge clk_sys);
        check("beats on wire", 64'(wire_q.size()), 64'(n));
        check("beats taken", 64'(n_taken[c]), 64'(n));
        check("beats received", 64'(rx_q[1-c].size()), 64'(n));
        for (int i = 0; i < n && i < wire_q.size() && i < rx_q[1-c].size(); i++) begin
            e = exp_inv(pat[i]);
            check("invert flags", 64'(inv_q[i]), 64'(e));
            check("wire data", wire_q[i], pat[i] ^ {{16{e[3]}}, {16{e[2]}}, {16{e[1]}}, {16{e[0]}}});
            check("rx data", rx_q[1-c][i], pat[i]);
        end
        clear();
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_cpu_burst();
        send(0, 3, 1'b1);
        expect_beats(0, 3);
    endtask

    task automatic t_agt_burst();
        send(1, 2, 1'b0);
        expect_beats(1, 2);
    endtask

    task automatic t_contend();
        @(posedge clk_sys);
        req[1] <= 1'b1;
        idle[1] <= 1'b1;
        last[1] <= 1'b1;
        txd[1] <= pat[2];
        repeat (4) @(posedge clk_sys);
        req[0] <= 1'b1;
        last[0] <= 1'b1;
        txd[0] <= pat[1];
        for (int k = 0; k < 6; k++) begin
            @(negedge clk_sys);
            check("agent in use while idling", 64'(bus_if.agt_in_use), 64'h1);
            check("cpu in use while agent busy", 64'(bus_if.cpu_in_use), 64'h0);
        end
        @(posedge clk_sys);
        idle[1] <= 1'b0;
        @(posedge clk_sys);
        req[1] <= 1'b0;
        last[1] <= 1'b0;
        for (int k = 0; k < 20 && bus_if.cpu_in_use !== 1'b1; k++)
            @(negedge clk_sys);
        check("cpu claim after release", 64'(bus_if.cpu_in_use), 64'h1);
        @(posedge clk_sys);
        req[0] <= 1'b0;
        last[0] <= 1'b0;
        repeat (6) @(posedge clk_sys);
        check("agent rx", rx_q[1].pop_front(), pat[1]);
        check("cpu rx", rx_q[0].pop_front(), pat[2]);
        clear();
    endtask

    task automatic t_flags();
        for (int v = 1; v >= 0; v--) begin
            @(posedge clk_sys);
            out_of_order_indication_req <= v[0];
            probe_req <= v[0];
            @(negedge clk_sys);
            check("out of order indication early", 64'(bus_if.out_of_order_indication), 64'(1 - v));
            @(negedge clk_sys);
            check("out of order indication", 64'(bus_if.out_of_order_indication), 64'(v));
            check("debug system reset", 64'(bus_if.debug_system_reset), 64'(v));
            @(negedge clk_sys);
            check("deferred early", 64'(deferred), 64'(1 - v));
            @(negedge clk_sys);
            check("deferred", 64'(deferred), 64'(v));
            check("probe reset seen", 64'(probe_seen), 64'(v));
        end
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_cpu_burst();
        t_agt_burst();
        t_contend();
        t_flags();
        results();
    end
endmodule // testbench
